/* design/fdcg_defs.svh */
// Constants for the floppy configuration and interrupt/DMA gating block.
// Included by the design files; holds definitions only.
`ifndef FDCG_DEFS_SVH
`define FDCG_DEFS_SVH

// ==========================================================
// Register indices (configuration data port, floppy device)
`define FDCG_IDX_MODE 8'hf0
`define FDCG_IDX_OPTION 8'hf1
`define FDCG_IDX_TYPE 8'hf2
`define FDCG_IDX_RSVD 8'hf3
`define FDCG_IDX_DRV0 8'hf4
`define FDCG_IDX_DRV1 8'hf5

// ==========================================================
// Reset values and writable masks
`define FDCG_RST_MODE 8'h0e
`define FDCG_RST_OPTION 8'h00
`define FDCG_RST_TYPE 8'hff
`define FDCG_RST_DRV 8'h00
`define FDCG_MASK_MODE 8'hcf
`define FDCG_MASK_OPTION 8'h0d
`define FDCG_MASK_TYPE 8'hff
`define FDCG_MASK_DRV 8'h5b

// ==========================================================
// Field positions
`define FDCG_MODE_ENH 0
`define FDCG_MODE_NONBURST 1
`define FDCG_MODE_IF_LO 2
`define FDCG_MODE_IF_HI 3
`define FDCG_MODE_PUSHPULL 6
`define FDCG_MODE_TRISTATE 7
`define FDCG_OPT_FWP 0
`define FDCG_OPT_DENS_LO 2
`define FDCG_OPT_DENS_HI 3
`define FDCG_DRV_TYPE_LO 0
`define FDCG_DRV_TYPE_HI 1
`define FDCG_DRV_RATE_LO 3
`define FDCG_DRV_RATE_HI 4
`define FDCG_DRV_PTS 6

// ==========================================================
// Density select codes
`define FDCG_DENS_FORCE1 2'b10
`define FDCG_DENS_FORCE0 2'b11

// ==========================================================
// Extended-control modes with interrupt always on
`define FDCG_ECR_FIFO 3'b010
`define FDCG_ECR_ECP 3'b011
`define FDCG_ECR_TEST 3'b110

// ==========================================================
// Logical device slots and DMA select range
`define FDCG_LD_FDC 0
`define FDCG_LD_SER1 1
`define FDCG_LD_SER2 2
`define FDCG_LD_PAR 3
`define FDCG_LD_SMB 4
`define FDCG_NUM_LD 5
`define FDCG_DMA_MIN 3'h1
`define FDCG_DMA_MAX 3'h3
`define FDCG_IRQ_NONE 4'h0
`define FDCG_BOOT_DRIVE 1'b0

`endif

/* design/fdcg_pkg.sv */
// Types shared by the floppy configuration and gating block.
// Assumes fdcg_defs.svh supplies all numeric constants.
package fdcg_pkg;

  // ==========================================================
  // Per logical device activation settings
  typedef struct packed {
    logic active;
    logic addr_valid;
    logic [3:0] irq_sel;
    logic [2:0] dma_sel;
  } fdcg_ld_cfg_t;

  // ==========================================================
  // Per drive setup fields
  typedef struct packed {
    logic precomp_disable;
    logic [1:0] rate_table_select;
    logic [1:0] drive_type_select;
  } fdcg_drive_cfg_t;

  // ==========================================================
  // Floppy mode fields
  typedef struct packed {
    logic enhanced_mode2;
    logic nonburst;
    logic [1:0] iface_mode;
    logic push_pull;
    logic tristate;
  } fdcg_mode_cfg_t;

endpackage : fdcg_pkg

/* design/fdcg_gate.sv */
// Interrupt and DMA request gate for one logical device.
// Assumes raw requests and enables come from logic on i_clk_sys.
`timescale 1ns/100ps
`include "fdcg_defs.svh"

module fdcg_gate (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Configuration and local enables
  input wire fdcg_pkg::fdcg_ld_cfg_t i_ld_cfg,
  input wire logic i_local_irq_en,
  input wire logic i_local_dma_en,
  // Raw requests from the unit
  input wire logic i_raw_irq,
  input wire logic i_raw_drq,
  // Gated requests
  output logic o_irq,
  output logic o_drq
);

  logic cfg_ok;
  logic irq_sel_ok;
  logic dma_sel_ok;
  logic irq_d;
  logic drq_d;

  assign cfg_ok = i_ld_cfg.active & i_ld_cfg.addr_valid;
  assign irq_sel_ok = (i_ld_cfg.irq_sel != `FDCG_IRQ_NONE);
  assign dma_sel_ok = (i_ld_cfg.dma_sel >= `FDCG_DMA_MIN) &&
                      (i_ld_cfg.dma_sel <= `FDCG_DMA_MAX);
  assign irq_d = i_raw_irq & cfg_ok & irq_sel_ok & i_local_irq_en;
  assign drq_d = i_raw_drq & cfg_ok & dma_sel_ok & i_local_dma_en;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
      o_drq <= 1'b0;
    end else begin
      o_irq <= irq_d;
      o_drq <= drq_d;
    end
  end

endmodule : fdcg_gate

/* design/fdcg_top.sv */
// Floppy vendor configuration registers plus per-device IRQ/DMA gating.
// Assumes config index/data decoding upstream and floppy core on i_clk_sys.
//
// What this block does
// - Suppress a device's IRQ and DMA when its own enable bit disables them.
// - Floppy IRQ and DMA off when transfer enable is zero or powered down.
// - Serial interrupt off while its aux output two bit is zero.
// - Parallel interrupt off in standard/EPP modes when its enable is zero.
// - In ECP, modes 010/011/110 interrupt always on; DMA follows extended transfer enable.
// - SMBus interrupt off while its interrupt enable bit is zero.
// - Registers reset only by power-on or hard reset, never soft reset.
// - Mode bit 0 selects enhanced mode; bits 3:2 select interface mode.
// - Mode bit 1: zero burst DMA, one non-burst DMA (default).
// - Mode bits 6/7 set drive type and tri-state, not parallel floppy pins.
// - Forced write protect asserts protect whenever either drive is selected.
// - Option bits 3:2 pass, force one or force zero the density signal.
// - Forced write protect applies to drives on the parallel port pins.
// - Drive type store: A in 1:0, B in 3:2, spare 7:4, resets 0xff.
// - Index 0xf3 reads zero and ignores writes.
// - Drive setup: type 1:0, rate table 4:3, precomp disable 6, rest zero.
// - Second drive setup mirrors the first drive's layout and defaults.
// - Drive 0 is always the boot drive.
// - Interrupt needs a non-zero level select and the local enable.
`timescale 1ns/100ps
`include "fdcg_defs.svh"

module fdcg_top #(
  parameter int unsigned FDC_OUT_W = 8
) (
  // Clock and reset (power-on or hard reset)
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Configuration data port access
  input wire logic i_cfg_fdc_sel,
  input wire logic [7:0] i_cfg_index,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // Logical device activation settings and raw requests
  input wire fdcg_pkg::fdcg_ld_cfg_t [`FDCG_NUM_LD-1:0] i_ld_cfg,
  input wire logic [`FDCG_NUM_LD-1:0] i_raw_irq,
  input wire logic [`FDCG_NUM_LD-1:0] i_raw_drq,
  // Floppy local enables
  input wire logic i_transfer_request_enable,
  input wire logic i_fdc_powered_down,
  // Serial local enables
  input wire logic i_ser1_aux_output_two,
  input wire logic i_ser2_aux_output_two,
  // Parallel local enables
  input wire logic i_pp_ecp_active,
  input wire logic [2:0] i_pp_ecr_mode,
  input wire logic i_parallel_int_enable,
  input wire logic i_extended_transfer_enable,
  // SMBus local enable
  input wire logic i_smbus_int_enable,
  // Gated requests
  output logic [`FDCG_NUM_LD-1:0] o_irq,
  output logic [`FDCG_NUM_LD-1:0] o_drq,
  // Write protect sources
  input wire logic i_write_protect_n,
  input wire logic i_pp_write_protect_n,
  input wire logic i_pp_fdc_active,
  input wire logic i_floppy_write_protect,
  input wire logic i_drive_select0_n,
  input wire logic i_drive_select1_n,
  output logic o_core_write_protect_n,
  output logic o_floppy_status_a_wp,
  // Density indication
  input wire logic i_density,
  output logic o_density,
  // Floppy output drivers
  input wire logic [FDC_OUT_W-1:0] i_fdc_out,
  output logic [FDC_OUT_W-1:0] o_fdc_pin_o,
  output logic [FDC_OUT_W-1:0] o_fdc_pin_oe,
  input wire logic [FDC_OUT_W-1:0] i_pp_fdc_out,
  output logic [FDC_OUT_W-1:0] o_pp_fdc_pin_o,
  output logic [FDC_OUT_W-1:0] o_pp_fdc_pin_oe,
  // Configuration fields toward the floppy core
  output fdcg_pkg::fdcg_mode_cfg_t o_mode_cfg,
  output logic [1:0] o_drive_a_type,
  output logic [1:0] o_drive_b_type,
  output fdcg_pkg::fdcg_drive_cfg_t o_drive0_cfg,
  output fdcg_pkg::fdcg_drive_cfg_t o_drive1_cfg,
  output logic o_boot_drive
);

  // ==========================================================
  // Register storage
  logic [7:0] mode_q;
  logic [7:0] option_q;
  logic [7:0] type_q;
  logic [7:0] drv0_q;
  logic [7:0] drv1_q;
  logic [7:0] mode_d;
  logic [7:0] option_d;
  logic [7:0] type_d;
  logic [7:0] drv0_d;
  logic [7:0] drv1_d;

  // access only when floppy device selected
  logic wr_ok;
  assign wr_ok = i_cfg_wr & i_cfg_fdc_sel;

  logic wr_mode;
  logic wr_option;
  logic wr_type;
  logic wr_drv0;
  logic wr_drv1;
  assign wr_mode = wr_ok & (i_cfg_index == `FDCG_IDX_MODE);
  assign wr_option = wr_ok & (i_cfg_index == `FDCG_IDX_OPTION);
  assign wr_type = wr_ok & (i_cfg_index == `FDCG_IDX_TYPE);
  assign wr_drv0 = wr_ok & (i_cfg_index == `FDCG_IDX_DRV0);
  assign wr_drv1 = wr_ok & (i_cfg_index == `FDCG_IDX_DRV1);

  // Reserved bits are masked at write so they always read zero
  assign mode_d = wr_mode ? (i_cfg_wdata & `FDCG_MASK_MODE) : mode_q;
  assign option_d = wr_option ? (i_cfg_wdata & `FDCG_MASK_OPTION) : option_q;
  assign type_d = wr_type ? (i_cfg_wdata & `FDCG_MASK_TYPE) : type_q;
  assign drv0_d = wr_drv0 ? (i_cfg_wdata & `FDCG_MASK_DRV) : drv0_q;
  assign drv1_d = wr_drv1 ? (i_cfg_wdata & `FDCG_MASK_DRV) : drv1_q;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= `FDCG_RST_MODE;
      option_q <= `FDCG_RST_OPTION;
      type_q <= `FDCG_RST_TYPE;
      drv0_q <= `FDCG_RST_DRV;
      drv1_q <= `FDCG_RST_DRV;
    end else begin
      mode_q <= mode_d;
      option_q <= option_d;
      type_q <= type_d;
      drv0_q <= drv0_d;
      drv1_q <= drv1_d;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rd_mux;
  logic rd_ok;
  logic [7:0] rdata_d;
  assign rd_ok = i_cfg_rd & i_cfg_fdc_sel;
  assign rd_mux = (i_cfg_index == `FDCG_IDX_MODE) ? mode_q :
                  (i_cfg_index == `FDCG_IDX_OPTION) ? option_q :
                  (i_cfg_index == `FDCG_IDX_TYPE) ? type_q :
                  (i_cfg_index == `FDCG_IDX_DRV0) ? drv0_q :
                  (i_cfg_index == `FDCG_IDX_DRV1) ? drv1_q : 8'h00;
  assign rdata_d = rd_ok ? rd_mux : 8'h00;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rdata <= 8'h00;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rdata <= rdata_d;
      o_cfg_rvalid <= rd_ok;
    end
  end

  // ==========================================================
  // Local enables and gating
  logic [`FDCG_NUM_LD-1:0] local_irq_en;
  logic [`FDCG_NUM_LD-1:0] local_dma_en;
  logic fdc_en;
  logic ecr_irq_on;
  logic par_irq_en;

  assign fdc_en = i_transfer_request_enable & ~i_fdc_powered_down;
  assign ecr_irq_on = (i_pp_ecr_mode == `FDCG_ECR_FIFO) ||
                      (i_pp_ecr_mode == `FDCG_ECR_ECP) ||
                      (i_pp_ecr_mode == `FDCG_ECR_TEST);
  assign par_irq_en = (i_pp_ecp_active & ecr_irq_on) | i_parallel_int_enable;

  assign local_irq_en[`FDCG_LD_FDC] = fdc_en;
  assign local_dma_en[`FDCG_LD_FDC] = fdc_en;
  assign local_irq_en[`FDCG_LD_SER1] = i_ser1_aux_output_two;
  assign local_irq_en[`FDCG_LD_SER2] = i_ser2_aux_output_two;
  assign local_dma_en[`FDCG_LD_SER1] = 1'b0;
  assign local_dma_en[`FDCG_LD_SER2] = 1'b0;
  assign local_irq_en[`FDCG_LD_PAR] = par_irq_en;
  assign local_dma_en[`FDCG_LD_PAR] = i_extended_transfer_enable;
  assign local_irq_en[`FDCG_LD_SMB] = i_smbus_int_enable;
  assign local_dma_en[`FDCG_LD_SMB] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < `FDCG_NUM_LD; g++) begin : g_gate
      fdcg_gate u_gate (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_ld_cfg(i_ld_cfg[g]),
        .i_local_irq_en(local_irq_en[g]),
        .i_local_dma_en(local_dma_en[g]),
        .i_raw_irq(i_raw_irq[g]),
        .i_raw_drq(i_raw_drq[g]),
        .o_irq(o_irq[g]),
        .o_drq(o_drq[g])
      );
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers for drive write protect inputs
  logic [1:0] wp_meta_q;
  logic [1:0] wp_sync_q;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_meta_q <= 2'b11;
      wp_sync_q <= 2'b11;
    end else begin
      wp_meta_q <= {i_pp_write_protect_n, i_write_protect_n};
      wp_sync_q <= wp_meta_q;
    end
  end

  // ==========================================================
  // Write protect combine
  logic any_select;
  logic wp_from_drive;
  logic wp_active;
  assign wp_from_drive = ~wp_sync_q[0] | (i_pp_fdc_active & ~wp_sync_q[1]);
  // Drive selects come from the core and cover both pin routes
  assign any_select = ~i_drive_select0_n | ~i_drive_select1_n;
  assign wp_active = i_floppy_write_protect | wp_from_drive |
                     (any_select & option_q[`FDCG_OPT_FWP]);

  // ==========================================================
  // Density override
  logic [1:0] dens_sel;
  logic density_d;
  assign dens_sel = option_q[`FDCG_OPT_DENS_HI:`FDCG_OPT_DENS_LO];
  assign density_d = (dens_sel == `FDCG_DENS_FORCE1) ? 1'b1 :
                     (dens_sel == `FDCG_DENS_FORCE0) ? 1'b0 : i_density;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_core_write_protect_n <= 1'b1;
      o_floppy_status_a_wp <= 1'b0;
      o_density <= 1'b0;
    end else begin
      o_core_write_protect_n <= ~wp_active;
      o_floppy_status_a_wp <= wp_active;
      o_density <= density_d;
    end
  end

  // ==========================================================
  // Floppy output drivers
  logic [FDC_OUT_W-1:0] fdc_oe_d;
  logic push_pull;
  logic tristate;
  assign push_pull = mode_q[`FDCG_MODE_PUSHPULL];
  assign tristate = mode_q[`FDCG_MODE_TRISTATE];
  // drive type and tri-state
  // Open drain only pulls low, so enable follows a low level
  assign fdc_oe_d = tristate ? '0 : (push_pull ? '1 : ~i_fdc_out);

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fdc_pin_o <= '1;
      o_fdc_pin_oe <= '0;
      o_pp_fdc_pin_o <= '1;
      o_pp_fdc_pin_oe <= '0;
    end else begin
      o_fdc_pin_o <= i_fdc_out;
      o_fdc_pin_oe <= fdc_oe_d;
      o_pp_fdc_pin_o <= i_pp_fdc_out;
      o_pp_fdc_pin_oe <= '1;
    end
  end

  // ==========================================================
  // Configuration fields toward the core
  // mode and interface fields
  assign o_mode_cfg.enhanced_mode2 = mode_q[`FDCG_MODE_ENH];
  assign o_mode_cfg.nonburst = mode_q[`FDCG_MODE_NONBURST];
  assign o_mode_cfg.iface_mode = mode_q[`FDCG_MODE_IF_HI:`FDCG_MODE_IF_LO];
  assign o_mode_cfg.push_pull = mode_q[`FDCG_MODE_PUSHPULL];
  assign o_mode_cfg.tristate = mode_q[`FDCG_MODE_TRISTATE];
  assign o_drive_a_type = type_q[1:0];
  assign o_drive_b_type = type_q[3:2];
  assign o_drive0_cfg.precomp_disable = drv0_q[`FDCG_DRV_PTS];
  assign o_drive0_cfg.rate_table_select = drv0_q[`FDCG_DRV_RATE_HI:`FDCG_DRV_RATE_LO];
  assign o_drive0_cfg.drive_type_select = drv0_q[`FDCG_DRV_TYPE_HI:`FDCG_DRV_TYPE_LO];
  assign o_drive1_cfg.precomp_disable = drv1_q[`FDCG_DRV_PTS];
  assign o_drive1_cfg.rate_table_select = drv1_q[`FDCG_DRV_RATE_HI:`FDCG_DRV_RATE_LO];
  assign o_drive1_cfg.drive_type_select = drv1_q[`FDCG_DRV_TYPE_HI:`FDCG_DRV_TYPE_LO];

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_boot_drive <= `FDCG_BOOT_DRIVE;
    end else begin
      o_boot_drive <= `FDCG_BOOT_DRIVE;
    end
  end

endmodule : fdcg_top

/* tb/fdcg_top_checker.sv */
// Port-level checker for the floppy configuration and gating block.
// Assumes it is bound into fdcg_top and sees only its ports.
`timescale 1ns/100ps

module fdcg_top_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Register port
  input wire logic i_cfg_fdc_sel,
  input wire logic [7:0] i_cfg_index,
  input wire logic i_cfg_rd,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  // Gating
  input wire logic [4:0] i_raw_irq,
  input wire logic i_transfer_request_enable,
  input wire logic i_fdc_powered_down,
  input wire logic i_ser1_aux_output_two,
  input wire logic i_smbus_int_enable,
  input wire logic [4:0] o_irq,
  input wire logic [4:0] o_drq,
  // Protect and boot
  input wire logic o_core_write_protect_n,
  input wire logic o_floppy_status_a_wp,
  input wire logic o_boot_drive
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================
  // Assertions
  AST_RVALID: assert property (o_cfg_rvalid == $past(i_cfg_rd & i_cfg_fdc_sel))
    else $error("read answer does not follow a selected read");
  AST_RSVD_ZERO: assert property ((i_cfg_rd && i_cfg_fdc_sel && i_cfg_index == 8'hf3)
    |=> o_cfg_rdata == 8'h00) else $error("reserved index read not zero");
  AST_FDC_GATE: assert property ((!i_transfer_request_enable || i_fdc_powered_down)
    |=> !o_irq[0] && !o_drq[0]) else $error("floppy request not gated");
  AST_SER_GATE: assert property (!i_ser1_aux_output_two |=> !o_irq[1])
    else $error("serial interrupt not gated");
  AST_SMB_GATE: assert property (!i_smbus_int_enable |=> !o_irq[4])
    else $error("smbus interrupt not gated");
  AST_NO_SER_DRQ: assert property (o_drq[2:1] == 2'b00 && !o_drq[4])
    else $error("dma request from a unit without dma");
  AST_NO_RAW: assert property ((o_irq & ~$past(i_raw_irq)) == 5'h00)
    else $error("interrupt without raw request");
  AST_WP_MIRROR: assert property (o_floppy_status_a_wp != o_core_write_protect_n)
    else $error("status protect bit differs from core protect");
  AST_BOOT: assert property (!o_boot_drive)
    else $error("boot drive not zero");

  // ==========================================================
  // Coverage
  COV_READ: cover property (o_cfg_rvalid);
  COV_PAR_IRQ: cover property (o_irq[3] && o_drq[3]);
  COV_WP: cover property (!o_core_write_protect_n);
endmodule : fdcg_top_checker

/* tb/fdcg_tb_top.sv */
// Self-checking bench for the floppy configuration and gating block.
// Assumes fdcg_top with default output width and the checker bound below.
`timescale 1ns/100ps

module fdcg_tb_top;
  logic i_clk_sys, i_sys_rst, i_cfg_fdc_sel, i_cfg_wr, i_cfg_rd, o_cfg_rvalid;
  logic [7:0] i_cfg_index, i_cfg_wdata, o_cfg_rdata;
  fdcg_pkg::fdcg_ld_cfg_t [4:0] i_ld_cfg;
  logic [4:0] i_raw_irq, i_raw_drq, o_irq, o_drq;
  logic i_transfer_request_enable, i_fdc_powered_down;
  logic i_ser1_aux_output_two, i_ser2_aux_output_two, i_pp_ecp_active;
  logic i_parallel_int_enable, i_extended_transfer_enable, i_smbus_int_enable;
  logic [2:0] i_pp_ecr_mode;
  logic i_write_protect_n, i_pp_write_protect_n, i_pp_fdc_active, i_floppy_write_protect;
  logic i_drive_select0_n, i_drive_select1_n, o_core_write_protect_n, o_floppy_status_a_wp;
  logic i_density, o_density, o_boot_drive;
  logic [7:0] i_fdc_out, o_fdc_pin_o, o_fdc_pin_oe, i_pp_fdc_out, o_pp_fdc_pin_o, o_pp_fdc_pin_oe;
  fdcg_pkg::fdcg_mode_cfg_t o_mode_cfg;
  logic [1:0] o_drive_a_type, o_drive_b_type;
  fdcg_pkg::fdcg_drive_cfg_t o_drive0_cfg, o_drive1_cfg;
  logic [10:0] en;
  logic [5:0] wp;
  int num_errors, n_compared;

  // Local enables and protect sources driven as vectors
  assign {i_transfer_request_enable, i_fdc_powered_down, i_ser1_aux_output_two,
          i_ser2_aux_output_two, i_pp_ecp_active, i_pp_ecr_mode, i_parallel_int_enable,
          i_extended_transfer_enable, i_smbus_int_enable} = en;
  assign {i_drive_select0_n, i_drive_select1_n, i_floppy_write_protect, i_write_protect_n,
          i_pp_write_protect_n, i_pp_fdc_active} = wp;

  fdcg_top dut (.*);

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================
  // Helpers
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task settle;
    // Covers the two-flop pin synchroniser and the output register
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask : settle

  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_cfg_wr <= 1'b1;
    i_cfg_index <= idx;
    i_cfg_wdata <= d;
    @(posedge i_clk_sys);
    i_cfg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_cfg_rd <= 1'b1;
    i_cfg_index <= idx;
    @(posedge i_clk_sys);
    i_cfg_rd <= 1'b0;
    #1;
    chk(o_cfg_rvalid, i_cfg_fdc_sel);
    chk(o_cfg_rdata, exp);
  endtask : rd

  task do_rst;
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
  endtask : do_rst

  // ==========================================================
  // Scenarios
  task t_defaults;
    rd(8'hf0, 8'h0e);
    rd(8'hf1, 8'h00);
    rd(8'hf2, 8'hff);
    rd(8'hf3, 8'h00);
    rd(8'hf4, 8'h00);
    rd(8'hf5, 8'h00);
    chk(o_mode_cfg, 8'h1c);
    chk(o_boot_drive, 8'h00);
  endtask : t_defaults

  task t_regs;
    logic [7:0] exp [6];
    exp = '{8'hcf, 8'h0d, 8'hff, 8'h00, 8'h5b, 8'h5b};
    for (int i = 0; i < 6; i++) wr(8'hf0 + 8'(i), 8'hff);
    for (int i = 0; i < 6; i++) rd(8'hf0 + 8'(i), exp[i]);
    chk(o_drive0_cfg, 8'h1f);
    chk(o_drive1_cfg, 8'h1f);
    wr(8'hf2, 8'h5a);
    rd(8'hf2, 8'h5a);
    chk({o_drive_b_type, o_drive_a_type}, 8'h0a);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    @(posedge i_clk_sys);
    i_cfg_fdc_sel <= 1'b0;
    wr(8'hf4, 8'h00);
    rd(8'hf4, 8'h00);
    @(posedge i_clk_sys);
    i_cfg_fdc_sel <= 1'b1;
    rd(8'hf4, 8'h5b);
    do_rst();
    t_defaults();
  endtask : t_regs

  task pin(input logic [7:0] m, input logic [7:0] oe, input logic [7:0] cfg);
    wr(8'hf0, m);
    settle();
    chk(o_fdc_pin_oe, oe);
    chk(o_pp_fdc_pin_oe, 8'hff);
    chk(o_pp_fdc_pin_o, 8'h3c);
    chk(o_mode_cfg, cfg);
  endtask : pin

  task g(input logic [10:0] e, input logic [4:0] ei, input logic [4:0] ed);
    @(posedge i_clk_sys);
    en <= e;
    settle();
    chk(o_irq, ei);
    chk(o_drq, ed);
  endtask : g

  task t_gate;
    g(11'h587, 5'h1f, 5'h09);
    g(11'h187, 5'h1e, 5'h08);
    g(11'h787, 5'h1e, 5'h08);
    g(11'h487, 5'h1d, 5'h09);
    g(11'h507, 5'h1b, 5'h09);
    g(11'h583, 5'h17, 5'h09);
    g(11'h586, 5'h0f, 5'h09);
    g(11'h585, 5'h1f, 5'h01);
    for (int m = 0; m < 8; m++) g(11'h5c3 | 11'(m << 3), (m == 2 || m == 3 || m == 6) ? 5'h1f : 5'h17, 5'h09);
    @(posedge i_clk_sys);
    i_ld_cfg[0].irq_sel <= 4'h0;
    i_ld_cfg[3].dma_sel <= 3'h4;
    g(11'h587, 5'h1e, 5'h01);
    @(posedge i_clk_sys);
    i_ld_cfg[0] <= {1'b1, 1'b1, 4'h5, 3'h2};
    i_ld_cfg[3] <= {1'b0, 1'b1, 4'h5, 3'h2};
    i_raw_irq <= 5'h0d;
    g(11'h587, 5'h05, 5'h01);
  endtask : t_gate

  task w(input logic [5:0] v, input logic ex_n);
    @(posedge i_clk_sys);
    wp <= v;
    settle();
    chk(o_core_write_protect_n, ex_n);
    chk(o_floppy_status_a_wp, !ex_n);
  endtask : w

  task t_wp;
    wr(8'hf1, 8'h01);
    w(6'b110110, 1'b1);
    w(6'b010110, 1'b0);
    w(6'b100110, 1'b0);
    wr(8'hf1, 8'h00);
    w(6'b100110, 1'b1);
    w(6'b111110, 1'b0);
    w(6'b110010, 1'b0);
    w(6'b110100, 1'b1);
    w(6'b110101, 1'b0);
  endtask : t_wp

  task d(input logic [7:0] opt, input logic din, input logic exp);
    wr(8'hf1, opt);
    @(posedge i_clk_sys);
    i_density <= din;
    settle();
    chk(o_density, exp);
  endtask : d

  task results;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ==========================================================
  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_cfg_fdc_sel = 1'b1;
    i_cfg_wr = 1'b0;
    i_cfg_rd = 1'b0;
    i_cfg_index = 8'h00;
    i_cfg_wdata = 8'h00;
    for (int k = 0; k < 5; k++) i_ld_cfg[k] = {1'b1, 1'b1, 4'h5, 3'h2};
    i_raw_irq = 5'h1f;
    i_raw_drq = 5'h1f;
    en = 11'h587;
    wp = 6'b110110;
    i_density = 1'b0;
    i_fdc_out = 8'h5a;
    i_pp_fdc_out = 8'h3c;
    num_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_defaults();
    t_regs();
    pin(8'h80, 8'h00, 8'h01);
    pin(8'h40, 8'hff, 8'h02);
    pin(8'h00, 8'ha5, 8'h00);
    pin(8'h05, 8'ha5, 8'h24);
    chk(o_fdc_pin_o, 8'h5a);
    t_gate();
    t_wp();
    d(8'h00, 1'b1, 1'b1);
    d(8'h04, 1'b0, 1'b0);
    d(8'h08, 1'b0, 1'b1);
    d(8'h0c, 1'b1, 1'b0);
    results();
  end

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    num_errors++;
    results();
  end
endmodule : fdcg_tb_top

bind fdcg_top fdcg_top_checker u_chk (.*);
